// >>> design/delay_interrupt_and_defer_unit.sv
// delayed one-shot interrupts with nested deferral of servicing
// assumes requests are single-cycle pulses, one per cycle at most
//
// Overview of operation
// - each started delay fires once, then goes inactive without rearming
// - cancel before expiry stops the timer; its handler never fires
// - spare tag on start is accepted and has no effect
// - start loads delay, runs a countdown, binds the handler number
// - expiry raises an interrupt running the bound handler
// - only delayed-interrupt handler numbers accepted; others rejected
// - codes 0000 ok, 8090 bad handler, 8091 bad delay, 80A0 not started
// - each defer postpones new events and increments the nest count, saturating at FF
// - deferral lasts until resumed or the current handler finishes
// - events during deferral are held pending and serviced later
// - each resume decrements the nest count by one, stopping at zero
// - defer and resume both return the current nest count
// - servicing resumes only when the nest count is zero
`timescale 1ns/1ps
`default_nettype none
`include "delay_irq_cfg.svh"

module delay_interrupt_and_defer_unit #(
    parameter int          TICK_CYCLES  = `TICK_CYCLES,
    parameter int          TIMERS       = `TIMER_COUNT,
    parameter logic [7:0]  HANDLER_BASE = `HANDLER_BASE
) (
    input  wire logic                       clk,           // 20 MHz clock
    input  wire logic                       reset_n,       // sync reset
    input  wire logic                       clk_en,        // freezes state
    input  wire delay_irq_pkg::request_type req,           // request group
    output var  delay_irq_pkg::answer_type  ans,           // answer group
    output logic                            irq_valid,     // handler launch
    output logic [7:0]                      irq_handler,   // handler to run
    input  wire logic                       irq_ack,       // launch taken
    input  wire logic                       handler_done,  // handler ended
    output logic                            servicing_on   // not deferred
);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int SW = $clog2(TIMERS);

    // requests after priority: start, cancel, defer, resume
    logic                         take_start;
    logic                         take_cancel;
    logic                         take_defer;
    logic                         take_resume;
    logic                         hnd_valid;
    logic [SW-1:0]                hnd_slot;
    // time base
    logic [TW-1:0]                tick_ff, nxt_tick;
    logic                         tick;
    // timer bank, one slot per handler
    logic [TIMERS-1:0]            act_ff,  nxt_act;
    logic [TIMERS-1:0]            pend_ff, nxt_pend;
    logic [15:0]                  cnt_ff   [TIMERS];
    logic [15:0]                  nxt_cnt  [TIMERS];
    // deferral
    logic [7:0]                   nest_ff, nxt_nest;
    // service sequencer
    delay_irq_pkg::svc_state_type st_ff, nxt_st;
    logic [SW-1:0]                sel_ff, nxt_sel;
    logic                         irq_v_ff, nxt_irq_v;
    logic [7:0]                   irq_h_ff, nxt_irq_h;
    logic                         launch;
    logic [SW-1:0]                launch_slot;
    // answer
    delay_irq_pkg::answer_type    nxt_ans;

    function automatic logic handler_ok(input logic [7:0] h);
        handler_ok = (h >= HANDLER_BASE) &&
                     ({1'b0, h} < ({1'b0, HANDLER_BASE} + 9'(TIMERS)));
    endfunction : handler_ok

    function automatic logic [SW-1:0] slot_of(input logic [7:0] h);
        logic [7:0] diff;
        diff    = h - HANDLER_BASE;
        slot_of = diff[SW-1:0];
    endfunction : slot_of

    function automatic logic delay_ok(input logic [15:0] d);
        delay_ok = (d >= `DELAY_MIN_MS) && (d <= `DELAY_MAX_MS);
    endfunction : delay_ok

    // lowest set slot wins
    function automatic logic [SW-1:0] first_set(input logic [TIMERS-1:0] v);
        first_set = '0;
        for (int i = TIMERS - 1; i >= 0; i--)
        begin
            if (v[i])
                first_set = SW'(i);
        end
    endfunction : first_set

    // spare_tag is never read
    assign take_start  = req.start;
    assign take_cancel = !req.start && req.cancel;
    assign take_defer  = !req.start && !req.cancel && req.defer;
    assign take_resume = !req.start && !req.cancel && !req.defer &&
                         req.resume;
    assign hnd_valid   = handler_ok(req.handler_number);
    assign hnd_slot    = slot_of(req.handler_number);
    assign tick        = (tick_ff == TW'(TICK_CYCLES - 1));

    // free-running time base, first tick may be partial
    always_comb
    begin
        nxt_tick = tick ? '0 : tick_ff + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            tick_ff <= '0;
        else if (clk_en)
            tick_ff <= nxt_tick;
    end

    // timer bank; cancel after expiry still clears pending
    always_comb
    begin
        nxt_act  = act_ff;
        nxt_pend = pend_ff;
        for (int i = 0; i < TIMERS; i++)
        begin
            nxt_cnt[i] = cnt_ff[i];
            if (act_ff[i] && tick)
            begin
                if (cnt_ff[i] == 16'h0001)
                begin
                    nxt_act[i]  = 1'b0;
                    nxt_pend[i] = 1'b1;
                    nxt_cnt[i]  = '0;
                end
                else
                begin
                    nxt_cnt[i] = cnt_ff[i] - 16'h0001;
                end
            end
        end
        // launch taken: the event is consumed, no rearm
        if (st_ff == delay_irq_pkg::st_service && irq_ack)
            nxt_pend[sel_ff] = 1'b0;
        // restart of a running slot reloads it
        if (take_start && hnd_valid && delay_ok(req.delay_value))
        begin
            nxt_act[hnd_slot]  = 1'b1;
            nxt_cnt[hnd_slot]  = req.delay_value;
            nxt_pend[hnd_slot] = 1'b0;
        end
        else if (take_cancel && hnd_valid)
        begin
            nxt_act[hnd_slot]  = 1'b0;
            nxt_pend[hnd_slot] = 1'b0;
            nxt_cnt[hnd_slot]  = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            act_ff  <= '0;
            pend_ff <= '0;
            for (int i = 0; i < TIMERS; i++)
                cnt_ff[i] <= '0;
        end
        else if (clk_en)
        begin
            act_ff  <= nxt_act;
            pend_ff <= nxt_pend;
            for (int i = 0; i < TIMERS; i++)
                cnt_ff[i] <= nxt_cnt[i];
        end
    end

    // nest counter, saturating at both ends
    always_comb
    begin
        // a finished handler drops every defer left behind
        nxt_nest = handler_done ? 8'h00 : nest_ff;
        if (take_defer && nxt_nest != `NEST_MAX)
            nxt_nest = nxt_nest + 8'h01;
        else if (take_resume && nxt_nest != 8'h00)
            nxt_nest = nxt_nest - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            nest_ff <= '0;
        else if (clk_en)
            nest_ff <= nxt_nest;
    end

    // service sequencer; pending events wait while deferred
    assign launch      = (nest_ff == 8'h00) && (pend_ff != '0);
    assign launch_slot = first_set(pend_ff);

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_sel   = sel_ff;
        nxt_irq_v = irq_v_ff;
        nxt_irq_h = irq_h_ff;
        case (st_ff)
            delay_irq_pkg::st_idle:
            begin
                if (launch)
                begin
                    nxt_sel   = launch_slot;
                    nxt_irq_v = 1'b1;
                    nxt_irq_h = HANDLER_BASE + 8'(launch_slot);
                    nxt_st    = delay_irq_pkg::st_service;
                end
            end
            delay_irq_pkg::st_service:
            begin
                if (irq_ack)
                begin
                    nxt_irq_v = 1'b0;
                    nxt_st    = delay_irq_pkg::st_handler;
                end
            end
            delay_irq_pkg::st_handler:
            begin
                if (handler_done)
                    nxt_st = delay_irq_pkg::st_idle;
            end
            default:
            begin
                nxt_st    = delay_irq_pkg::st_idle;
                nxt_irq_v = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_ff    <= delay_irq_pkg::st_idle;
            sel_ff   <= '0;
            irq_v_ff <= 1'b0;
            irq_h_ff <= '0;
        end
        else if (clk_en)
        begin
            st_ff    <= nxt_st;
            sel_ff   <= nxt_sel;
            irq_v_ff <= nxt_irq_v;
            irq_h_ff <= nxt_irq_h;
        end
    end

    // one-cycle answer to every taken request
    always_comb
    begin
        nxt_ans = '0;
        if (take_start)
        begin
            nxt_ans.done = 1'b1;
            if (!hnd_valid)
                nxt_ans.return_code = `RC_BAD_HANDLER;
            else if (!delay_ok(req.delay_value))
                nxt_ans.return_code = `RC_BAD_DELAY;
            else
                nxt_ans.return_code = `RC_OK;
        end
        else if (take_cancel)
        begin
            nxt_ans.done = 1'b1;
            if (!hnd_valid)
                nxt_ans.return_code = `RC_BAD_HANDLER;
            else if (!act_ff[hnd_slot] && !pend_ff[hnd_slot])
                nxt_ans.return_code = `RC_NOT_STARTED;
            else
                nxt_ans.return_code = `RC_OK;
        end
        else if (take_defer || take_resume)
        begin
            nxt_ans.done        = 1'b1;
            nxt_ans.return_code = {8'h00, nxt_nest};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ans <= '0;
        else if (clk_en)
            ans <= nxt_ans;
    end

    // launch outputs straight from flip-flops
    assign irq_valid    = irq_v_ff;
    assign irq_handler  = irq_h_ff;
    assign servicing_on = (nest_ff == 8'h00);

endmodule : delay_interrupt_and_defer_unit

`default_nettype wire

// >>> design/delay_irq_cfg.svh
// constants for the delay interrupt and defer unit
// assumes a 20 MHz clock and a 1 ms time base derived from it
`ifndef DELAY_IRQ_CFG_SVH
`define DELAY_IRQ_CFG_SVH

`define CLK_PERIOD_NS       50
`define TICK_PERIOD_NS      1000000
`define TICK_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define DELAY_MIN_MS        16'h0001
`define DELAY_MAX_MS        16'hEA60
`define RC_OK               16'h0000
`define RC_BAD_HANDLER      16'h8090
`define RC_BAD_DELAY        16'h8091
`define RC_NOT_STARTED      16'h80A0
`define TIMER_COUNT         4
`define HANDLER_BASE        8'h14
`define NEST_MAX            8'hFF

`endif

// >>> design/delay_irq_pkg.sv
// types for the delay interrupt and defer unit
// used only through scoped names
`default_nettype none
package delay_irq_pkg;

    typedef struct packed {
        logic        start;          // start a delay
        logic        cancel;         // cancel a delay
        logic        defer;          // defer servicing
        logic        resume;         // resume servicing
        logic [7:0]  handler_number; // handler id
        logic [15:0] delay_value;    // delay in ms
        logic [15:0] spare_tag;      // accepted, ignored
    } request_type;

    typedef struct packed {
        logic        done;           // answer strobe
        logic [15:0] return_code;    // code or nest count
    } answer_type;

    typedef enum logic [2:0] {
        st_idle    = 3'b001,
        st_service = 3'b010,
        st_handler = 3'b100
    } svc_state_type;

endpackage : delay_irq_pkg
`default_nettype wire

// >>> bench/delay_irq_props.sv
// assertions for the delay interrupt and defer unit
// bound to the unit; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module delay_irq_props (
    input wire logic                       clk,          // clock
    input wire logic                       reset_n,      // sync reset
    input wire logic                       clk_en,       // enable
    input wire delay_irq_pkg::request_type req,          // requests
    input wire delay_irq_pkg::answer_type  ans,          // answers
    input wire logic                       irq_valid,    // launch
    input wire logic [7:0]                 irq_handler,  // handler
    input wire logic                       irq_ack,      // launch taken
    input wire logic                       handler_done, // handler end
    input wire logic                       servicing_on  // not deferred
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic any_req;
    logic ok_h;
    assign any_req = req.start | req.cancel | req.defer | req.resume;
    assign ok_h = req.handler_number inside {[8'h14:8'h17]};
    sequence s_deferred;
        (!servicing_on && !handler_done)[*2];
    endsequence
    sequence s_nest_answer;
        ans.done ##0 $past(clk_en && !req.start && !req.cancel
            && (req.defer || req.resume));
    endsequence
    property p_answer; clk_en && any_req |=> ans.done; endproperty
    property p_quiet; clk_en && !any_req |=> !ans.done; endproperty
    property p_bad_h;
        clk_en && req.start && !ok_h |=> ans.return_code == 16'h8090;
    endproperty
    property p_bad_d;
        clk_en && req.start && ok_h && (req.delay_value == 16'h0000
            || req.delay_value > 16'hEA60) |=> ans.return_code == 16'h8091;
    endproperty
    property p_defer;
        clk_en && req.defer && !req.start && !req.cancel && servicing_on
            |=> ans.return_code == 16'h0001 && !servicing_on;
    endproperty
    property p_count;
        s_nest_answer |-> servicing_on == (ans.return_code == 16'h0000);
    endproperty
    property p_hold;
        irq_valid && !irq_ack |=> irq_valid && $stable(irq_handler);
    endproperty
    property p_range; irq_valid |-> irq_handler inside
        {[8'h14:8'h17]}; endproperty
    property p_freeze;
        !clk_en |=> $stable(ans) && $stable(irq_valid)
            && $stable(servicing_on);
    endproperty
    property p_held; s_deferred ##0 !irq_valid |=> !irq_valid; endproperty
    property p_done_clr;
        clk_en && handler_done && !req.defer |=> servicing_on;
    endproperty
    property p_ack; clk_en && irq_valid && irq_ack |=> !irq_valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_quiet: assert property (p_quiet) else $error("stray answer");
    a_bad_h: assert property (p_bad_h) else $error("handler code");
    a_bad_d: assert property (p_bad_d) else $error("delay code");
    a_defer: assert property (p_defer) else $error("defer count");
    a_count: assert property (p_count) else $error("nest state");
    a_hold: assert property (p_hold) else $error("launch dropped");
    a_range: assert property (p_range) else $error("bad launch");
    a_held: assert property (p_held) else $error("launch deferred");
    a_done_clr: assert property (p_done_clr) else $error("end");
    a_ack: assert property (p_ack) else $error("launch repeated");
    a_freeze: assert property (p_freeze) else $error("not frozen");
endmodule : delay_irq_props
bind delay_interrupt_and_defer_unit delay_irq_props u_props (
    .clk, .reset_n, .clk_en, .req, .ans, .irq_valid, .irq_handler,
    .irq_ack, .handler_done, .servicing_on
);
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the delay interrupt and defer unit
// runs the unit with a 4-cycle tick
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                       clk;
    logic                       reset_n;
    logic                       clk_en;
    logic                       irq_ack;
    logic                       handler_done;
    delay_irq_pkg::request_type req;
    delay_irq_pkg::answer_type  ans;
    logic                       irq_valid;
    logic [7:0]                 irq_handler;
    logic                       servicing_on;
    logic [31:0]                seed;
    logic [7:0]                 h;
    logic [15:0]                d;
    int                         bad_count = 0;
    int                         total_checks = 0;
    int                         cycles = 0;
    int                         nest = 0;
    bit                         run [4];
    delay_interrupt_and_defer_unit #(.TICK_CYCLES(4)) DUT (
        .clk, .reset_n, .clk_en, .req, .ans, .irq_valid,
        .irq_handler, .irq_ack, .handler_done, .servicing_on
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic check(logic [15:0] got, logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // k: 0 start, 1 cancel, 2 defer, 3 resume
    task automatic op(int k, logic [7:0] hn, logic [15:0] dv);
        delay_irq_pkg::request_type r;
        logic [15:0]                e;
        int                         s;
        s = int'(hn) - 20;
        if (k < 2 && (s < 0 || s > 3))
            e = 16'h8090;
        else if (k == 0 && (dv == 16'h0000 || dv > 16'hEA60))
            e = 16'h8091;
        else if (k < 2)
        begin
            e = (k == 0 || run[s]) ? 16'h0000 : 16'h80A0;
            run[s] = (k == 0);
        end
        else
        begin
            nest = (k == 2) ? nest + (nest < 255) : nest - (nest > 0);
            e = 16'(nest);
        end
        r = '0;
        {r.start, r.cancel, r.defer, r.resume} = 4'(8 >> k);
        r.handler_number = hn;
        r.delay_value = dv;
        r.spare_tag = 16'(rnd() >> 16);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= '0;
        #1;
        check(16'(ans.done), 16'h0001);
        check(ans.return_code, e);
    endtask : op
    task automatic no_irq(int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            check(16'(irq_valid), 16'h0000);
        end
    endtask : no_irq
    // hold the enable low; a frozen timer must not fire
    task automatic freeze(int n);
        @(posedge clk);
        clk_en <= 1'b0;
        no_irq(n);
        @(posedge clk);
        clk_en <= 1'b1;
    endtask : freeze
    task automatic end_handler();
        @(posedge clk);
        handler_done <= 1;
        @(posedge clk);
        handler_done <= 0;
        nest = 0;
        #1;
        check(16'(servicing_on), 16'h0001);
    endtask : end_handler
    task automatic wait_irq(logic [7:0] hn);
        for (int n = 0; n < 60 && irq_valid !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        check(16'(irq_handler), 16'(hn));
        run[hn - 20] = 0;
        @(posedge clk);
        irq_ack <= 1;
        @(posedge clk);
        irq_ack <= 0;
        end_handler();
    endtask : wait_irq
    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    initial
    begin
        seed = 32'h2c2c_f4ee;
        reset_n = 0;
        clk_en = 1;
        irq_ack = 0;
        handler_done = 0;
        req = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1;
        for (int i = 0; i < 8; i++)
        begin
            h = 8'(16 + rnd() % 8);
            d = (rnd() % 3 == 0) ? 16'h0000 : 16'(2 + rnd() % 2);
            op(0, h, d);
            if (h inside {[20:23]} && d != 0)
            begin
                op(1, h, 0);
                op(1, h, 0);
            end
        end
        no_irq(20);
        op(0, 20, 16'hEA61);
        op(0, 20, 16'hEA60);
        op(1, 20, 0);
        op(0, 21, 2);
        wait_irq(21);
        no_irq(16);
        op(1, 21, 0);
        repeat (3) op(2, 0, 0);
        op(0, 22, 1);
        no_irq(16);
        repeat (3) op(3, 0, 0);
        wait_irq(22);
        repeat (2) op(2, 0, 0);
        op(0, 23, 1);
        no_irq(12);
        end_handler();
        wait_irq(23);
        op(3, 0, 0);
        op(2, 0, 0);
        op(0, 20, 1);
        no_irq(12);
        op(1, 20, 0);
        op(3, 0, 0);
        no_irq(16);
        op(0, 21, 1);
        freeze(12);
        wait_irq(21);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
